// >>> verilog/petm_monitor.sv
// Per-port error and time-out monitor: parity error tally, queue
// time-out enable, per-queue time-out flags, error message select,
// and an interrupt over an APB register slave.
// Assumes one clock, core_clk; all inputs synchronous to it.
`timescale 1ns/100ps
`include "petm_params.svh"

module petm_monitor #(
   parameter int unsigned NUM_Q = `PETM_NQ,
   parameter int unsigned TALLY_W = `PETM_TALLY_W,
   parameter int unsigned TO_EPOCHS = `PETM_TO_EPOCHS,
   parameter int unsigned AGE_W = `PETM_AGE_W
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic porRst,
   input wire logic clkEn,
   input wire petm_pkg::petm_apb_req_t apbReq,
   output logic [`PETM_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic parityErr,
   input wire logic epochTick,
   input wire petm_pkg::petm_queue_in_t queueIn,
   output logic [NUM_Q-1:0] queueDiscard,
   output petm_pkg::petm_err_msg_t errMsg,
   output logic irq
);
   import petm_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic busSetup;
   logic busAccess;
   logic rdSetup;
   logic wrDone;
   logic addrHit;
   logic [`PETM_DATA_W-1:0] rdMux;
   logic tallyClr;
   logic stsClr;
   logic [TALLY_W-1:0] tally;
   logic [NUM_Q-1:0] discardEv;

   logic [`PETM_DATA_W-1:0] prdata_r;
   logic [`PETM_DATA_W-1:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;

   logic toEnable_r;
   logic toEnable_nxt;
   logic [`PETM_RSEL_W-1:0] rsel_r;
   logic [`PETM_RSEL_W-1:0] rsel_nxt;

   logic [NUM_Q-1:0] flags_r;
   logic [NUM_Q-1:0] flags_nxt;
   logic [NUM_Q-1:0] flagRise;
   logic [`PETM_IRQ_W-1:0] irqSts_r;
   logic [`PETM_IRQ_W-1:0] irqSts_nxt;
   logic [`PETM_IRQ_W-1:0] irqMask_r;
   logic [`PETM_IRQ_W-1:0] irqMask_nxt;
   logic irq_r;
   logic irq_nxt;

   petm_err_msg_t errMsg_r;
   petm_err_msg_t errMsg_nxt;

   // ----------------------------------------------------------------
   // APB decode and read mux
   // ----------------------------------------------------------------
   // Side effects of a read fire at the setup edge, where the read
   // data is captured, so the value seen and the clear are atomic
   always_comb begin
      busSetup = apbReq.psel && !apbReq.penable;
      busAccess = apbReq.psel && apbReq.penable && pready_r;
      rdSetup = busSetup && !apbReq.pwrite;
      wrDone = busAccess && apbReq.pwrite;
      addrHit = 1'b1;
      rdMux = '0;
      case (apbReq.paddr)
         `PETM_OFF_TALLY: begin
            rdMux[TALLY_W-1:0] = tally;
         end
         `PETM_OFF_TOEN: begin
            rdMux[`PETM_TOEN_BIT] = toEnable_r;
         end
         `PETM_OFF_FLAGS: begin
            rdMux[NUM_Q-1:0] = flags_r;
         end
         `PETM_OFF_RSEL: begin
            rdMux[`PETM_RSEL_W-1:0] = rsel_r;
         end
         `PETM_OFF_IRQ_STS: begin
            rdMux[`PETM_IRQ_W-1:0] = irqSts_r;
         end
         `PETM_OFF_IRQ_MASK: begin
            rdMux[`PETM_IRQ_W-1:0] = irqMask_r;
         end
         default: begin
            addrHit = 1'b0;
         end
      endcase
      tallyClr = rdSetup && apbReq.paddr == `PETM_OFF_TALLY;
      stsClr = rdSetup && apbReq.paddr == `PETM_OFF_IRQ_STS;
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // One access cycle always; answer is ready by the access phase
   always_comb begin
      pready_nxt = busSetup;
      pslverr_nxt = busSetup && !addrHit;
      prdata_nxt = rdSetup ? rdMux : '0;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (clkEn) begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Parity error tally
   // ----------------------------------------------------------------
   petm_sat_counter #(
      .W(TALLY_W)
   ) u_tally (
      .clk(core_clk),
      .porRst(porRst),
      .clkEn(clkEn),
      .inc(parityErr),
      .clr(tallyClr),
      .count(tally)
   );

   // ----------------------------------------------------------------
   // Sticky configuration: enable and report selectors
   // ----------------------------------------------------------------
   // Reserved bits are dropped on write and read back as zero
   always_comb begin
      toEnable_nxt = toEnable_r;
      rsel_nxt = rsel_r;
      if (wrDone && apbReq.paddr == `PETM_OFF_TOEN) begin
         toEnable_nxt = apbReq.pwdata[`PETM_TOEN_BIT];
      end
      if (wrDone && apbReq.paddr == `PETM_OFF_RSEL) begin
         rsel_nxt = apbReq.pwdata[`PETM_RSEL_W-1:0];
      end
   end

   // Survives a port reset; only power-on reset restores defaults
   always_ff @(posedge core_clk or posedge porRst) begin
      if (porRst) begin
         toEnable_r <= `PETM_TOEN_RST;
         rsel_r <= `PETM_RSEL_RST;
      end else if (clkEn) begin
         toEnable_r <= toEnable_nxt;
         rsel_r <= rsel_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Queue aging, one per input queue
   // ----------------------------------------------------------------
   generate
      for (genvar q = 0; q < NUM_Q; q++) begin : g_age
         petm_queue_aging #(
            .AGE_W(AGE_W),
            .LIMIT(TO_EPOCHS)
         ) u_age (
            .clk(core_clk),
            .rst(sys_rst),
            .clkEn(clkEn),
            .enable(toEnable_r),
            .epochTick(epochTick),
            .headValid(queueIn.headValid[q]),
            .headPop(queueIn.headPop[q]),
            .discard(discardEv[q])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Time-out flags, interrupt status and mask
   // ----------------------------------------------------------------
   // Set wins over a same-cycle clear so no event slips past
   always_comb begin
      flags_nxt = flags_r;
      if (wrDone && apbReq.paddr == `PETM_OFF_FLAGS) begin
         flags_nxt = flags_r & ~apbReq.pwdata[NUM_Q-1:0];
      end
      flags_nxt = flags_nxt | discardEv;
      flagRise = discardEv & ~flags_r;
      irqMask_nxt = irqMask_r;
      if (wrDone && apbReq.paddr == `PETM_OFF_IRQ_MASK) begin
         irqMask_nxt = apbReq.pwdata[`PETM_IRQ_W-1:0];
      end
      irqSts_nxt = stsClr ? '0 : irqSts_r;
      irqSts_nxt[`PETM_IRQ_PAR_BIT] = irqSts_nxt[`PETM_IRQ_PAR_BIT] |
         parityErr;
      irqSts_nxt[`PETM_IRQ_Q_LSB +: NUM_Q] =
         irqSts_nxt[`PETM_IRQ_Q_LSB +: NUM_Q] | discardEv;
      irq_nxt = |(irqSts_nxt & irqMask_nxt);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= '0;
         irqSts_r <= '0;
         irqMask_r <= '0;
         irq_r <= 1'b0;
      end else if (clkEn) begin
         flags_r <= flags_nxt;
         irqSts_r <= irqSts_nxt;
         irqMask_r <= irqMask_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Error message toward the root
   // ----------------------------------------------------------------
   // Several queues rising together yield one message of the highest
   // selected severity code; the link carries one message per cycle
   always_comb begin
      errMsg_nxt.sev = PETM_SEV_NONE_C;
      for (int q = 0; q < NUM_Q; q++) begin
         if (flagRise[q] && rsel_r[2*q +: 2] > errMsg_nxt.sev) begin
            errMsg_nxt.sev = rsel_r[2*q +: 2];
         end
      end
      errMsg_nxt.valid = errMsg_nxt.sev != PETM_SEV_NONE_C;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         errMsg_r <= '0;
      end else if (clkEn) begin
         errMsg_r <= errMsg_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   localparam petm_sev_t PETM_SEV_NONE_C = 2'h0;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign queueDiscard = discardEv;
   assign errMsg = errMsg_r;
   assign irq = irq_r;

endmodule : petm_monitor

// >>> verilog/petm_params.svh
// Constants of the port error and time-out monitor: register offsets,
// field positions, reset values and timing counts.
// Assumes it is included by bare name by every file that needs it.
`ifndef PETM_PARAMS_SVH
`define PETM_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PETM_ADDR_W 12
`define PETM_DATA_W 32
`define PETM_NQ 4
`define PETM_TALLY_W 8
`define PETM_AGE_W 4

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PETM_OFF_TALLY 12'h74c
`define PETM_OFF_TOEN 12'h750
`define PETM_OFF_FLAGS 12'h754
`define PETM_OFF_RSEL 12'h758
`define PETM_OFF_IRQ_STS 12'h780
`define PETM_OFF_IRQ_MASK 12'h784

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PETM_TOEN_BIT 0
`define PETM_TOEN_RST 1'b1
`define PETM_RSEL_FIELD_W 2
`define PETM_RSEL_W 8
`define PETM_RSEL_RST 8'h82
`define PETM_IRQ_W 5
`define PETM_IRQ_PAR_BIT 0
`define PETM_IRQ_Q_LSB 1

// ----------------------------------------------------------------
// Timing: core time-out is this many time-stamp epochs
// ----------------------------------------------------------------
`define PETM_TO_EPOCHS 2

`endif

// >>> verilog/petm_pkg.sv
// Types of the port error and time-out monitor.
// Assumes petm_params.svh is on the include path.
`include "petm_params.svh"

package petm_pkg;

   // Error message severity sent toward the root
   typedef enum logic [1:0] {
      PETM_SEV_NONE = 2'h0,
      PETM_SEV_COR = 2'h1,
      PETM_SEV_NONFATAL = 2'h3,
      PETM_SEV_FATAL = 2'h2
   } petm_sev_dummy_t;

   typedef logic [1:0] petm_sev_t;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`PETM_ADDR_W-1:0] paddr;
      logic [`PETM_DATA_W-1:0] pwdata;
   } petm_apb_req_t;

   // Head-of-queue state from the switch core, one bit per queue
   typedef struct packed {
      logic [`PETM_NQ-1:0] headValid;
      logic [`PETM_NQ-1:0] headPop;
   } petm_queue_in_t;

   // Error message request toward the upstream port
   typedef struct packed {
      logic valid;
      petm_sev_t sev;
   } petm_err_msg_t;

endpackage : petm_pkg

// >>> verilog/petm_sat_counter.sv
// Saturating event tally with clear; kept on the power-on reset only.
// Assumes inc and clr are single-cycle, synchronous to clk.
`timescale 1ns/100ps

module petm_sat_counter #(
   parameter int unsigned W = 8
) (
   input wire logic clk,
   input wire logic porRst,
   input wire logic clkEn,
   input wire logic inc,
   input wire logic clr,
   output logic [W-1:0] count
);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   // ----------------------------------------------------------------
   // Next count
   // ----------------------------------------------------------------
   // Clear with a coincident event leaves one so nothing is lost
   always_comb begin
      count_nxt = count_r;
      if (clr) begin
         count_nxt = inc ? W'(1) : '0;
      end else if (inc && count_r != {W{1'b1}}) begin
         count_nxt = count_r + W'(1);
      end
   end

   // Power-on reset only, so the tally survives a port reset
   always_ff @(posedge clk or posedge porRst) begin
      if (porRst) begin
         count_r <= '0;
      end else if (clkEn) begin
         count_r <= count_nxt;
      end
   end

   assign count = count_r;

endmodule : petm_sat_counter

// >>> verilog/petm_queue_aging.sv
// Ages the head packet of one input queue in time-stamp epochs and
// pulses a discard when it has waited the core time-out limit.
// Assumes epochTick is a one-cycle pulse from the time-stamp logic.
`timescale 1ns/100ps

module petm_queue_aging #(
   parameter int unsigned AGE_W = 4,
   parameter int unsigned LIMIT = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic enable,
   input wire logic epochTick,
   input wire logic headValid,
   input wire logic headPop,
   output logic discard
);

   logic [AGE_W-1:0] age_r;
   logic [AGE_W-1:0] age_nxt;
   logic discard_r;
   logic discard_nxt;

   // ----------------------------------------------------------------
   // Age and discard
   // ----------------------------------------------------------------
   // Age restarts on each new head; disabled ports never discard
   always_comb begin
      discard_nxt = enable && headValid && !headPop && epochTick &&
         age_r == AGE_W'(LIMIT - 1);
      age_nxt = age_r;
      if (!enable || !headValid || headPop || discard_nxt) begin
         age_nxt = '0;
      end else if (epochTick) begin
         age_nxt = age_r + AGE_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         age_r <= '0;
         discard_r <= 1'b0;
      end else if (clkEn) begin
         age_r <= age_nxt;
         discard_r <= discard_nxt;
      end
   end

   assign discard = discard_r;

endmodule : petm_queue_aging

// >>> testbench/petm_monitor_checker.sv
// Checker: concurrent assertions on the monitor's ports.
// Assumes it is bound to petm_monitor and sees only its ports.
`timescale 1ns/100ps
`include "petm_params.svh"

module petm_monitor_checker
   import petm_pkg::*;
#(
   parameter int unsigned NUM_Q = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic porRst,
   input wire logic clkEn,
   input wire petm_pkg::petm_apb_req_t apbReq,
   input wire logic [`PETM_DATA_W-1:0] prdata,
   input wire logic parityErr,
   input wire logic epochTick,
   input wire petm_pkg::petm_queue_in_t queueIn,
   input wire logic [NUM_Q-1:0] queueDiscard,
   input wire petm_pkg::petm_err_msg_t errMsg
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst || porRst);

   // ----------------------------------------
   // Tally read sequences
   // ----------------------------------------
   // Setup cycle of a tally read
   logic rdTally;
   assign rdTally = apbReq.psel && !apbReq.penable && !apbReq.pwrite &&
      clkEn && apbReq.paddr == `PETM_OFF_TALLY;
   // Read, access and idle cycle, no error anywhere
   sequence readQuiet;
      (rdTally && !parityErr) ##1 !parityErr [*2];
   endsequence
   // Error lands on the clearing setup edge itself
   sequence readHit;
      (rdTally && parityErr) ##1 !parityErr [*2];
   endsequence
   // One error in the idle cycle after a clearing read
   sequence readThenErr;
      (rdTally && !parityErr) ##1 !parityErr ##1 parityErr;
   endsequence

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_TALLY_CLEAR: assert property (
      readQuiet ##1 rdTally |=> prdata == 32'h0000_0000)
      else $error("tally not cleared by read");
   AST_TALLY_KEEP: assert property (
      readHit ##1 rdTally |=> prdata == 32'h0000_0001)
      else $error("error during clearing read lost");
   AST_TALLY_INC: assert property (
      readThenErr ##1 rdTally |=> prdata == 32'h0000_0001)
      else $error("tally did not step by one");
   AST_DISCARD_HEAD: assert property (
      (queueDiscard & ~$past(queueIn.headValid)) == '0)
      else $error("discard without a waiting head");
   AST_DISCARD_TICK: assert property (
      queueDiscard != '0 |-> $past(epochTick))
      else $error("discard not on an epoch boundary");
   AST_DISCARD_ONE: assert property (
      queueDiscard != '0 |=> queueDiscard == '0)
      else $error("discard pulse longer than one cycle");
   AST_MSG_CAUSE: assert property (
      errMsg.valid |-> $past(queueDiscard) != '0)
      else $error("message without a new time-out");
   AST_MSG_CODE: assert property (
      errMsg.valid |-> errMsg.sev != 2'h0)
      else $error("message with severity none");
endmodule : petm_monitor_checker

bind petm_monitor petm_monitor_checker #(.NUM_Q(NUM_Q)) chk (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .porRst(porRst),
   .clkEn(clkEn),
   .apbReq(apbReq),
   .prdata(prdata),
   .parityErr(parityErr),
   .epochTick(epochTick),
   .queueIn(queueIn),
   .queueDiscard(queueDiscard),
   .errMsg(errMsg)
);

// >>> testbench/petm_core_model.sv
// Partner: switch core queues, time-stamp epochs and the root side.
// Assumes one clock; load requests come from the bench as pulses.
`timescale 1ns/100ps

module petm_core_model #(
   parameter int unsigned EPOCH = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] loadMask,
   input wire logic [3:0] queueDiscard,
   input wire petm_pkg::petm_err_msg_t errMsg,
   output logic epochTick,
   output petm_pkg::petm_queue_in_t queueIn,
   output int msgCount,
   output logic [1:0] lastSev
);
   import petm_pkg::*;
   int tickCnt;

   // Free-running epochs; a discarded head leaves its queue for good
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt <= 0;
         epochTick <= 1'b0;
         queueIn <= '0;
         msgCount <= 0;
         lastSev <= 2'h0;
      end else begin
         tickCnt <= (tickCnt == EPOCH - 1) ? 0 : tickCnt + 1;
         epochTick <= (tickCnt == EPOCH - 1);
         queueIn.headValid <= (queueIn.headValid | loadMask) & ~queueDiscard;
         if (errMsg.valid) begin
            msgCount <= msgCount + 1;
            lastSev <= errMsg.sev;
         end
      end
   end
endmodule : petm_core_model

// >>> testbench/tb_top.sv
// Testbench: APB register tests of the port error and time-out monitor.
// Assumes the checker is bound by its own file.
`timescale 1ns/100ps
`include "petm_params.svh"

module tb_top;
   import petm_pkg::*;
   logic core_clk = 0;
   logic sys_rst = 1;
   logic porRst = 1;
   logic clkEn = 1;
   logic parityErr = 0;
   logic [3:0] loadMask = 0;
   petm_apb_req_t apbReq = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, irq, epochTick, err;
   logic [3:0] queueDiscard;
   logic [1:0] lastSev;
   petm_queue_in_t queueIn;
   petm_err_msg_t errMsg;
   int msgCount;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;

   petm_monitor dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .porRst(porRst), .clkEn(clkEn), .apbReq(apbReq), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .parityErr(parityErr),
      .epochTick(epochTick), .queueIn(queueIn),
      .queueDiscard(queueDiscard), .errMsg(errMsg), .irq(irq));
   petm_core_model partner (.core_clk(core_clk), .sys_rst(sys_rst),
      .loadMask(loadMask), .queueDiscard(queueDiscard), .errMsg(errMsg),
      .epochTick(epochTick), .queueIn(queueIn), .msgCount(msgCount),
      .lastSev(lastSev));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   // Whole run is a few hundred cycles; far above that means a hang
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // pe[0]: parity error with setup; pe[1]: in the idle cycle after
   task automatic apb(input logic wr, input logic [11:0] addr,
         input logic [31:0] wdata, input logic [1:0] pe);
      @(posedge core_clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
         pwdata: wdata};
      parityErr <= pe[0];
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      parityErr <= 1'b0;
      @(negedge core_clk);
      while (pready !== 1'b1) @(negedge core_clk);
      rd = prdata;
      err = pslverr;
      @(posedge core_clk);
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      parityErr <= pe[1];
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
         input string n);
      apb(1'b0, a, 32'h0000_0000, 2'b00);
      chk(n, e, rd);
   endtask : rdchk

   task automatic pulses(input int n);
      @(posedge core_clk);
      parityErr <= 1'b1;
      repeat (n) @(posedge core_clk);
      parityErr <= 1'b0;
   endtask : pulses

   // Present a head in queue q, then, if waitGone, wait until it is discarded
   task automatic load(input int q, input logic waitGone);
      @(posedge core_clk);
      loadMask <= 4'h1 << q;
      @(posedge core_clk);
      loadMask <= 4'h0;
      @(negedge core_clk);
      while (waitGone && queueIn.headValid[q] !== 1'b0) @(negedge core_clk);
      repeat (3) @(negedge core_clk);
   endtask : load

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      porRst <= 1'b0;
      rdchk(`PETM_OFF_TALLY, 32'h0, "tally");
      rdchk(`PETM_OFF_TOEN, 32'h1, "enable");
      rdchk(`PETM_OFF_FLAGS, 32'h0, "flags");
      rdchk(`PETM_OFF_RSEL, 32'h82, "select");
      apb(1'b0, 12'h7f0, 32'h0, 2'b00);
      chk("unmapped", 32'h1, {31'h0, err});
      $display("test reset values done");
      pulses(3);
      rdchk(`PETM_OFF_TALLY, 32'h3, "tally");
      rdchk(`PETM_OFF_TALLY, 32'h0, "tally");
      pulses(300);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, `PETM_OFF_TALLY, 32'h0, 2'b01);
      chk("tally", 32'hff, rd);
      apb(1'b0, `PETM_OFF_TALLY, 32'h0, 2'b10);
      chk("tally", 32'h1, rd);
      rdchk(`PETM_OFF_TALLY, 32'h1, "tally");
      apb(1'b1, `PETM_OFF_IRQ_MASK, 32'h1, 2'b00);
      repeat (2) @(negedge core_clk);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(`PETM_OFF_IRQ_STS, 32'h1, "irq status");
      apb(1'b1, `PETM_OFF_IRQ_MASK, 32'h1e, 2'b00);
      repeat (2) @(negedge core_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test parity tally done");
      apb(1'b1, `PETM_OFF_RSEL, 32'he4, 2'b00);
      apb(1'b1, `PETM_OFF_TOEN, 32'h0, 2'b00);
      load(0, 1'b0);
      repeat (40) @(negedge core_clk);
      chk("held head", 32'h1, {31'h0, queueIn.headValid[0]});
      apb(1'b1, `PETM_OFF_TOEN, 32'h1, 2'b00);
      // Select 0xe4 gives queue q the report code q
      for (int q = 0; q < 4; q++) begin
         load(q, 1'b1);
         rdchk(`PETM_OFF_FLAGS, (32'h2 << q) - 1, "flags");
         chk("messages", q, msgCount);
         chk("severity", q, {30'h0, lastSev});
      end
      load(3, 1'b1);
      chk("messages", 32'h3, msgCount);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(`PETM_OFF_IRQ_STS, 32'h1e, "irq status");
      apb(1'b1, `PETM_OFF_FLAGS, 32'h5, 2'b00);
      rdchk(`PETM_OFF_FLAGS, 32'ha, "flags");
      apb(1'b1, `PETM_OFF_FLAGS, 32'ha, 2'b00);
      rdchk(`PETM_OFF_FLAGS, 32'h0, "flags");
      $display("test queue time-outs done");
      apb(1'b1, `PETM_OFF_TOEN, 32'h0, 2'b00);
      pulses(2);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      sys_rst <= 1'b0;
      rdchk(`PETM_OFF_TOEN, 32'h0, "enable");
      rdchk(`PETM_OFF_RSEL, 32'he4, "select");
      rdchk(`PETM_OFF_TALLY, 32'h2, "tally");
      @(posedge core_clk);
      porRst <= 1'b1;
      @(posedge core_clk);
      porRst <= 1'b0;
      rdchk(`PETM_OFF_TOEN, 32'h1, "enable");
      rdchk(`PETM_OFF_RSEL, 32'h82, "select");
      rdchk(`PETM_OFF_TALLY, 32'h0, "tally");
      $display("test sticky fields done");
      wrap_up();
   end
endmodule : tb_top
